// File: verilog/sbp_pkg.sv
// Shared constants and types for the per-block protect-bit logic
package sbp_pkg;
   // System clock rate and derived cycle counts
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned T_PROG_US = 200;
   localparam int unsigned T_ERASE_US = 45_000;
   localparam int unsigned PROG_CYC = T_PROG_US * CLK_PER_US;
   localparam int unsigned ERASE_CYC = T_ERASE_US * CLK_PER_US;
   localparam int unsigned TMR_W = 20;

   // Array geometry: 128 blocks of 256KB, index taken from address bits 24..18
   localparam int unsigned NUM_BLOCKS = 128;
   localparam int unsigned BLK_W = 7;
   localparam int unsigned BLK_LSB = 18;
   localparam logic [NUM_BLOCKS-1:0] PPB_FACTORY = {NUM_BLOCKS{1'b1}};
   localparam logic [NUM_BLOCKS-1:0] DYB_RESET = {NUM_BLOCKS{1'b1}};

   // Serial command codes
   localparam logic [7:0] OPC_RD_STATUS = 8'h05;
   localparam logic [7:0] OPC_RD_DYB = 8'he0;
   localparam logic [7:0] OPC_WR_DYB = 8'he1;
   localparam logic [7:0] OPC_RD_PPB = 8'he2;
   localparam logic [7:0] OPC_PG_PPB = 8'he3;
   localparam logic [7:0] OPC_ER_PPB = 8'he4;
   localparam logic [7:0] OPC_CLR_LOCK = 8'ha6;
   localparam logic [7:0] OPC_UNLOCK = 8'ha9;

   // Bit counts at which a frame is complete, and the count at which the bit counter saturates
   localparam logic [6:0] LEN_OPC = 7'h08;
   localparam logic [6:0] LEN_ADDR = 7'h28;
   localparam logic [6:0] LEN_DYB = 7'h30;
   localparam logic [6:0] LEN_UNLOCK = 7'h48;
   localparam logic [6:0] LEN_MAX = 7'h7f;

   // Register port map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_QSEL = 8'h08;
   localparam logic [7:0] REG_QRES = 8'h0c;
   localparam int unsigned CTRL_SOFT_RST = 0;
   localparam int unsigned CTRL_CLR_FAIL = 1;
   localparam int unsigned CTRL_CLR_LOCK = 2;

   typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_PREP, ST_ERASE} sbp_op_state_type;

   typedef struct packed {
      logic pwd_mode;
      logic lock;
      logic fail;
      logic busy;
   } sbp_status_type;

   typedef struct packed {
      logic sck;
      logic cs_n;
      logic si;
   } sbp_link_type;

   localparam sbp_link_type LINK_IDLE = 3'b010;
endpackage

// File: verilog/sbp_protect.sv
// Per-block persistent/dynamic write-protect logic with serial command front end
`timescale 1ns/100ps
// Overview of operation
// - 128 blocks of 256KB, one bit pair each
// - Persistent bits survive resets, kept non-volatile
// - Program clears one bit; erase sets all
// - Erase preprograms internally before erasing
// - Busy and fail visible in status
// - Program takes page time, erase sector time
// - No array data while persistent bit programs
// - Erase has no address, hits all
// - Factory state of persistent bits is one
// - Read command returns addressed persistent bit
// - Dynamic bits volatile, freely rewritable per block
// - Dynamic bit matters only if persistent erased
// - Dynamic write: zero protects, one unprotects
// - Lock latch zero freezes all persistent bits
// - Locked program/erase refused and flagged failed
// - Persistent mode: reset sets lock latch
// - Persistent mode: no command sets lock
// - Password mode: reset clears lock latch
// - Password mode: only unlock sets lock
// - Protected when either bit is zero
// - Dynamic bits unprotected after any reset
// - Soft reset keeps lock; clear command only
module sbp_protect #(
   parameter int unsigned P_ERASE_CYCLES = sbp_pkg::ERASE_CYC,
   parameter logic [63:0] P_PASSWORD = 64'hffff_ffff_ffff_ffff
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_password_mode,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic [sbp_pkg::NUM_BLOCKS-1:0] o_protect_map,
   output logic o_array_read_block,
   output logic o_busy
);

   function automatic logic [sbp_pkg::BLK_W-1:0] blk_idx(input logic [31:0] addr);
      blk_idx = addr[sbp_pkg::BLK_LSB +: sbp_pkg::BLK_W];
   endfunction

   sbp_pkg::sbp_link_type s1_q, s2_q, s3_q, flt_q, prev_q;
   logic sck_rise, sck_fall, cs_rise, cs_active;
   logic [63:0] sh_q;
   logic [6:0] cnt_q;
   logic [7:0] op_q;
   logic [7:0] op_next;
   logic [63:0] sh_next;
   logic [7:0] out_q;
   logic out_act_q;
   sbp_pkg::sbp_op_state_type state_q;
   logic [sbp_pkg::TMR_W-1:0] tmr_q;
   logic [sbp_pkg::BLK_W-1:0] tgt_q;
   // one bit pair per block; factory value all ones
   logic [sbp_pkg::NUM_BLOCKS-1:0] ppb_q = sbp_pkg::PPB_FACTORY;
   logic [sbp_pkg::NUM_BLOCKS-1:0] dyb_q;
   logic lock_q, pwd_q, fail_q;
   logic [sbp_pkg::BLK_W-1:0] qsel_q;
   logic idle, go_prog, go_erase, go_dyb, go_clr, go_unl, unl_ok, refused;
   logic wr_ctrl, soft_rst, clr_fail, clr_lock;
   sbp_pkg::sbp_status_type status;

   // Three-stage sampling; only stages two and three are compared
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         s1_q <= sbp_pkg::LINK_IDLE;
         s2_q <= sbp_pkg::LINK_IDLE;
         s3_q <= sbp_pkg::LINK_IDLE;
         flt_q <= sbp_pkg::LINK_IDLE;
         prev_q <= sbp_pkg::LINK_IDLE;
      end else begin
         s1_q <= {i_sck, i_cs_n, i_si};
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= sbp_pkg::sbp_link_type'((~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q));
         prev_q <= flt_q;
      end
   end

   assign cs_active = ~flt_q.cs_n;
   assign sck_rise = cs_active & flt_q.sck & ~prev_q.sck;
   assign sck_fall = cs_active & ~flt_q.sck & prev_q.sck;
   assign cs_rise = flt_q.cs_n & ~prev_q.cs_n;
   assign sh_next = {sh_q[62:0], flt_q.si};
   assign op_next = sh_next[7:0];

   // Frame shifter: counts bits, catches the opcode after eight
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         sh_q <= 64'h0;
         cnt_q <= 7'h00;
         op_q <= 8'h00;
      end else if (!cs_active) begin
         cnt_q <= 7'h00;
      end else if (sck_rise) begin
         sh_q <= sh_next;
         if (cnt_q != sbp_pkg::LEN_MAX) begin
            cnt_q <= cnt_q + 7'h01;
         end
         if (cnt_q == sbp_pkg::LEN_OPC - 7'h01) begin
            op_q <= op_next;
         end
      end
   end

   // Commands act at chip-select release and only with an exact bit count,
   // so a truncated or padded frame does nothing
   assign idle = (state_q == sbp_pkg::ST_IDLE);
   assign go_prog = cs_rise && idle && op_q == sbp_pkg::OPC_PG_PPB && cnt_q == sbp_pkg::LEN_ADDR;
   assign go_erase = cs_rise && idle && op_q == sbp_pkg::OPC_ER_PPB && cnt_q == sbp_pkg::LEN_OPC;
   assign go_dyb = cs_rise && idle && op_q == sbp_pkg::OPC_WR_DYB && cnt_q == sbp_pkg::LEN_DYB;
   assign go_clr = cs_rise && idle && op_q == sbp_pkg::OPC_CLR_LOCK && cnt_q == sbp_pkg::LEN_OPC;
   assign go_unl = cs_rise && idle && op_q == sbp_pkg::OPC_UNLOCK && cnt_q == sbp_pkg::LEN_UNLOCK;
   // unlock only in password mode with exact match
   assign unl_ok = go_unl && pwd_q && (sh_q == P_PASSWORD);
   // locked program or erase is refused
   assign refused = ((go_prog || go_erase) && !lock_q) || (go_unl && !unl_ok);

   assign wr_ctrl = i_reg_wr && (i_reg_addr == sbp_pkg::REG_CTRL);
   assign soft_rst = wr_ctrl && i_reg_wdata[sbp_pkg::CTRL_SOFT_RST];
   assign clr_fail = wr_ctrl && i_reg_wdata[sbp_pkg::CTRL_CLR_FAIL];
   assign clr_lock = wr_ctrl && i_reg_wdata[sbp_pkg::CTRL_CLR_LOCK];

   assign status = '{pwd_mode: pwd_q, lock: lock_q, fail: fail_q, busy: !idle};

   // program one page time; erase runs a preprogram pass then a sector erase time
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_q <= sbp_pkg::ST_IDLE;
         tmr_q <= '0;
         tgt_q <= '0;
      end else begin
         unique case (state_q)
            sbp_pkg::ST_IDLE: begin
               if (go_prog && lock_q) begin
                  state_q <= sbp_pkg::ST_PROG;
                  tmr_q <= sbp_pkg::TMR_W'(sbp_pkg::PROG_CYC - 1);
                  tgt_q <= blk_idx(sh_q[31:0]);
               end else if (go_erase && lock_q) begin
                  state_q <= sbp_pkg::ST_PREP;
                  tmr_q <= sbp_pkg::TMR_W'(sbp_pkg::PROG_CYC - 1);
               end
            end
            sbp_pkg::ST_PROG: begin
               if (tmr_q == '0) begin
                  state_q <= sbp_pkg::ST_IDLE;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            sbp_pkg::ST_PREP: begin
               if (tmr_q == '0) begin
                  state_q <= sbp_pkg::ST_ERASE;
                  tmr_q <= sbp_pkg::TMR_W'(P_ERASE_CYCLES - 1);
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            sbp_pkg::ST_ERASE: begin
               if (tmr_q == '0) begin
                  state_q <= sbp_pkg::ST_IDLE;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
         endcase
      end
   end

   // persistent bits take no reset; they start at the factory value
   always_ff @(posedge i_clk_sys) begin
      if (state_q == sbp_pkg::ST_PROG && tmr_q == '0) begin
         ppb_q[tgt_q] <= 1'b0;
      end else if (state_q == sbp_pkg::ST_PREP && tmr_q == '0) begin
         ppb_q <= '0;
      end else if (state_q == sbp_pkg::ST_ERASE && tmr_q == '0) begin
         ppb_q <= sbp_pkg::PPB_FACTORY;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || soft_rst) begin
         dyb_q <= sbp_pkg::DYB_RESET;
      end else if (go_dyb) begin
         dyb_q[blk_idx(sh_q[39:8])] <= sh_q[0];
      end
   end

   // Mode strap is taken at hardware reset and held until the next one
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         pwd_q <= i_password_mode;
         // persistent mode resets to one; password mode to zero
         lock_q <= !i_password_mode;
      end else if (go_clr || clr_lock) begin
         // clear only; soft reset leaves latch alone
         lock_q <= 1'b0;
      end else if (unl_ok) begin
         // no set path outside password mode
         lock_q <= 1'b1;
      end
   end

   // A refusal in the same cycle as a software clear still sets the flag
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         fail_q <= 1'b0;
      end else if (refused) begin
         fail_q <= 1'b1;
      end else if (clr_fail || soft_rst) begin
         fail_q <= 1'b0;
      end
   end

   // Register port: one-cycle read latency, unmapped reads zero
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         qsel_q <= '0;
      end else if (i_reg_wr && i_reg_addr == sbp_pkg::REG_QSEL) begin
         qsel_q <= i_reg_wdata[sbp_pkg::BLK_W-1:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !i_reg_rd) begin
         o_reg_rdata <= 32'h0;
      end else begin
         unique case (i_reg_addr)
            sbp_pkg::REG_STATUS: o_reg_rdata <= {28'h0, status};
            sbp_pkg::REG_QSEL: o_reg_rdata <= {25'h0, qsel_q};
            sbp_pkg::REG_QRES: o_reg_rdata <= {29'h0, ~(ppb_q[qsel_q] & dyb_q[qsel_q]), dyb_q[qsel_q],
                                               ppb_q[qsel_q]};
            default: o_reg_rdata <= 32'h0;
         endcase
      end
   end

   // Serial reply: load on the rising edge that completes the header,
   // shift on falling edges; the byte rotates so polling can continue
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !cs_active) begin
         out_q <= 8'h00;
         out_act_q <= 1'b0;
      end else if (sck_rise && cnt_q == sbp_pkg::LEN_OPC - 7'h01 && op_next == sbp_pkg::OPC_RD_STATUS) begin
         out_q <= {4'h0, status};
         out_act_q <= 1'b1;
      end else if (sck_rise && cnt_q == sbp_pkg::LEN_ADDR - 7'h01 && op_q == sbp_pkg::OPC_RD_PPB) begin
         // persistent bit read; addressed bit repeated in all eight reply bits
         out_q <= {8{ppb_q[blk_idx(sh_next[31:0])]}};
         out_act_q <= 1'b1;
      end else if (sck_rise && cnt_q == sbp_pkg::LEN_ADDR - 7'h01 && op_q == sbp_pkg::OPC_RD_DYB) begin
         out_q <= {8{dyb_q[blk_idx(sh_next[31:0])]}};
         out_act_q <= 1'b1;
      end else if (sck_fall && out_act_q) begin
         out_q <= {out_q[6:0], out_q[7]};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !cs_active) begin
         o_so <= 1'b0;
         o_so_oe_n <= 1'b1;
      end else if (sck_fall && out_act_q) begin
         o_so <= out_q[7];
         o_so_oe_n <= 1'b0;
      end
   end

   // Block status outputs
   always_ff @(posedge i_clk_sys) begin
      // protected when either bit is zero; dynamic bit only counts if persistent is one
      o_protect_map <= ~(ppb_q & dyb_q);
      // array reads blocked during persistent program
      o_array_read_block <= !i_reset && (state_q == sbp_pkg::ST_PROG);
      o_busy <= !i_reset && !idle;
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   sequence s_prog_run;
      (state_q == sbp_pkg::ST_PROG)[*8];
   endsequence

   sequence s_prep_run;
      (state_q == sbp_pkg::ST_PREP)[*8];
   endsequence

   property p_lock_after_reset;
      $past(i_reset) |-> (lock_q == !pwd_q);
   endproperty
   a_lock_after_reset: assert property (p_lock_after_reset) else $error("lock latch wrong after reset");

   property p_lock_no_set_persist;
      (!pwd_q && !lock_q) |=> !lock_q;
   endproperty
   a_lock_no_set_persist: assert property (p_lock_no_set_persist) else $error("lock set in persistent mode");

   property p_lock_rise_cause;
      $rose(lock_q) |-> $past(unl_ok) && pwd_q;
   endproperty
   a_lock_rise_cause: assert property (p_lock_rise_cause) else $error("lock rose without unlock");

   property p_locked_refused;
      ((go_prog || go_erase) && !lock_q) |=> fail_q && $stable(ppb_q) && state_q == sbp_pkg::ST_IDLE;
   endproperty
   a_locked_refused: assert property (p_locked_refused) else $error("locked command not refused");

   property p_prog_timing;
      (go_prog && lock_q) |=> s_prog_run ##0 o_array_read_block && o_busy;
   endproperty
   a_prog_timing: assert property (p_prog_timing) else $error("program did not run busy");

   property p_erase_prep;
      (go_erase && lock_q) |=> s_prep_run ##0 o_busy;
   endproperty
   a_erase_prep: assert property (p_erase_prep) else $error("erase skipped preprogram");

   property p_prog_one_bit;
      (state_q == sbp_pkg::ST_PROG && tmr_q == '0) |=> ppb_q == ($past(ppb_q) & ~(128'h1 << $past(tgt_q)));
   endproperty
   a_prog_one_bit: assert property (p_prog_one_bit) else $error("program hit wrong bits");

   property p_erase_all;
      (state_q == sbp_pkg::ST_ERASE && tmr_q == '0) |=> ppb_q == sbp_pkg::PPB_FACTORY ##1 !o_busy;
   endproperty
   a_erase_all: assert property (p_erase_all) else $error("erase did not set all bits");

   property p_soft_reset;
      soft_rst |=> (dyb_q == sbp_pkg::DYB_RESET) && $stable(lock_q);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset effect wrong");

   property p_protect_map;
      1'b1 |=> o_protect_map == ~($past(ppb_q) & $past(dyb_q));
   endproperty
   a_protect_map: assert property (p_protect_map) else $error("protect map mismatch");

endmodule

// File: testbench/sbp_host_model.sv
// Serial host model that frames protect-bit commands toward the device
`timescale 1ns/100ps
module sbp_host_model (
   input wire logic i_clk_sys,
   input wire logic i_so,
   input wire logic i_so_oe_n,
   output sbp_pkg::sbp_link_type o_link
);
   initial o_link = sbp_pkg::LINK_IDLE;

   // Clock idles low between frames; released si keeps toggling so a stale bit never looks valid
   task automatic send(input logic [71:0] bits, input int nbits, input int nrx, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      @(posedge i_clk_sys);
      o_link.cs_n <= 1'b0;
      for (i = 0; i < nbits + nrx; i++) begin
         o_link.sck <= 1'b0;
         o_link.si <= (i < nbits) ? bits[71-i] : ~o_link.si;
         repeat (4) @(posedge i_clk_sys);
         o_link.sck <= 1'b1;
         repeat (4) @(posedge i_clk_sys);
         // Reply bit taken just before the next fall, with the output enable required low
         if (i >= nbits) begin
            rx = {rx[6:0], (i_so_oe_n === 1'b0) ? i_so : 1'bx};
         end
      end
      o_link.sck <= 1'b0;
      o_link.si <= ~o_link.si;
      repeat (4) @(posedge i_clk_sys);
      o_link.cs_n <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
   endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the per-block protect-bit logic
`timescale 1ns/100ps
module tb_top;
   localparam logic [63:0] PWD = 64'h0123_4567_89ab_cdef;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic i_password_mode = 1'b0;
   sbp_pkg::sbp_link_type link;
   logic o_so;
   logic o_so_oe_n;
   logic [7:0] i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [31:0] o_reg_rdata;
   logic [sbp_pkg::NUM_BLOCKS-1:0] o_protect_map;
   logic o_array_read_block;
   logic o_busy;
   logic [31:0] rd;
   logic [7:0] rx;
   int errors = 0;
   int compares = 0;
   int cnt;

   always #25 i_clk_sys = ~i_clk_sys;

   sbp_host_model host (.i_clk_sys(i_clk_sys), .i_so(o_so), .i_so_oe_n(o_so_oe_n), .o_link(link));

   // Erase time shortened so the whole run stays brief
   sbp_protect #(.P_ERASE_CYCLES(20), .P_PASSWORD(PWD)) uut (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_password_mode(i_password_mode),
      .i_sck(link.sck), .i_cs_n(link.cs_n), .i_si(link.si), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .o_protect_map(o_protect_map), .o_array_read_block(o_array_read_block),
      .o_busy(o_busy)
   );

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
   endtask

   task automatic st(input logic [3:0] e);
      reg_rd(sbp_pkg::REG_STATUS, rd);
      check(rd, {28'h0, e});
   endtask

   task automatic qres(input logic [6:0] b, input logic [2:0] e);
      reg_wr(sbp_pkg::REG_QSEL, {25'h0, b});
      reg_rd(sbp_pkg::REG_QRES, rd);
      check(rd, {29'h0, e});
   endtask

   function automatic logic [31:0] ba(input logic [6:0] b);
      return {7'h00, b, 18'h00000};
   endfunction

   task automatic cmd(input logic [7:0] opc, input logic [63:0] tail, input int n, input int nrx);
      host.send({opc, tail}, n, nrx, rx);
   endtask

   // A hang in a busy phase ends the run as a failure
   task automatic busy_len(output int n);
      n = 0;
      while (o_busy === 1'b1 && n < 10000) begin
         @(posedge i_clk_sys);
         n++;
      end
      if (n >= 10000) begin
         errors++;
         finish_test();
      end
   endtask

   task automatic hw_reset(input logic m);
      @(posedge i_clk_sys);
      i_reset <= 1'b1;
      i_password_mode <= m;
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
   endtask

   initial begin
      hw_reset(1'b0);
      st(4'h4);
      check(o_protect_map, '0);
      qres(7'h05, 3'h3);
      reg_rd(8'h10, rd);
      check(rd, 32'h0);
      cmd(sbp_pkg::OPC_WR_DYB, {ba(7'h05), 8'h00, 24'h0}, 48, 0);
      cmd(sbp_pkg::OPC_WR_DYB, {ba(7'h7f), 8'h00, 24'h0}, 48, 0);
      qres(7'h05, 3'h5);
      check(o_protect_map, {1'b1, 121'h0, 1'b1, 5'h0});
      cmd(sbp_pkg::OPC_RD_DYB, {ba(7'h7f), 32'h0}, 40, 8);
      check(rx, 8'h00);
      cmd(sbp_pkg::OPC_WR_DYB, {ba(7'h7f), 8'h01, 24'h0}, 48, 0);
      cmd(sbp_pkg::OPC_RD_DYB, {ba(7'h7f), 32'h0}, 40, 8);
      check(rx, 8'hff);
      check(o_protect_map, 128'h20);
      cmd(sbp_pkg::OPC_PG_PPB, {ba(7'h7f), 32'h0}, 40, 0);
      check({o_busy, o_array_read_block}, 2'b11);
      st(4'h5);
      busy_len(cnt);
      check(cnt >= 3980 && cnt <= 4005, 1'b1);
      cmd(sbp_pkg::OPC_RD_PPB, {ba(7'h7f), 32'h0}, 40, 8);
      check(rx, 8'h00);
      qres(7'h7e, 3'h3);
      check(o_protect_map, {1'b1, 121'h0, 1'b1, 5'h0});
      cmd(sbp_pkg::OPC_ER_PPB, 64'h0, 8, 0);
      busy_len(cnt);
      check(cnt >= 4010 && cnt <= 4030, 1'b1);
      qres(7'h7f, 3'h3);
      check(o_protect_map, 128'h20);
      cmd(sbp_pkg::OPC_PG_PPB, {ba(7'h03), 32'h0}, 40, 0);
      // Serial status poll while the program still runs
      cmd(sbp_pkg::OPC_RD_STATUS, 64'h0, 8, 8);
      check(rx, 8'h05);
      busy_len(cnt);
      reg_wr(sbp_pkg::REG_CTRL, 32'h1);
      repeat (3) @(posedge i_clk_sys);
      check(o_protect_map, 128'h8);
      st(4'h4);
      cmd(sbp_pkg::OPC_CLR_LOCK, 64'h0, 8, 0);
      st(4'h0);
      cmd(sbp_pkg::OPC_PG_PPB, {ba(7'h09), 32'h0}, 40, 0);
      st(4'h2);
      qres(7'h09, 3'h3);
      cmd(sbp_pkg::OPC_ER_PPB, 64'h0, 8, 0);
      qres(7'h03, 3'h6);
      reg_wr(sbp_pkg::REG_CTRL, 32'h2);
      cmd(sbp_pkg::OPC_UNLOCK, PWD, 72, 0);
      st(4'h2);
      hw_reset(1'b0);
      st(4'h4);
      qres(7'h03, 3'h6);
      hw_reset(1'b1);
      st(4'h8);
      cmd(sbp_pkg::OPC_UNLOCK, ~PWD, 72, 0);
      st(4'ha);
      reg_wr(sbp_pkg::REG_CTRL, 32'h2);
      cmd(sbp_pkg::OPC_UNLOCK, PWD, 72, 0);
      st(4'hc);
      finish_test();
   end
endmodule
